// file: verilog/dag_pkg.sv
// package: constants and types for the data address generation unit
package dag_pkg;
   localparam int unsigned EA_W = 16;
   localparam int unsigned XA_W = 24;
   localparam int unsigned RPAG_W = 10;
   localparam int unsigned WPAG_W = 9;
   localparam int unsigned NREG = 16;
   localparam int unsigned FREG_W = 13;
   localparam int unsigned LIT5_W = 5;
   localparam int unsigned LIT10_W = 10;
   localparam int unsigned EA_TOP_BIT = 15;
   localparam int unsigned RPAG_PSV_BIT = 9;
   localparam logic [3:0] DEFAULT_WORK_REG_ZERO_IDX = 4'h0;
   localparam logic [9:0] READ_PAGE_RST = 10'h001;
   localparam logic [8:0] WRITE_PAGE_RST = 9'h001;
   localparam logic [15:0] DEFAULT_WORK_REG_RST = 16'h0000;
   localparam logic [15:0] MOD_START_RST = 16'h0000;
   localparam logic [15:0] MOD_END_RST = 16'hffff;
   localparam logic [3:0] MOD_SEL_NONE = 4'hf;

   // addressing mode requested by the decoder
   typedef enum logic [2:0] {
      DAG_FILE_DIRECT,
      DAG_REG_DIRECT,
      DAG_INDIRECT,
      DAG_POST_MOD,
      DAG_PRE_MOD,
      DAG_REG_INDEXED,
      DAG_LIT_OFFSET,
      DAG_LITERAL
   } dag_mode_e;

   // second operand source of a three-operand instruction
   typedef enum logic [1:0] {
      DAG_OP2_REG,
      DAG_OP2_LIT5,
      DAG_OP2_LIT10
   } dag_op2_e;
endpackage

// file: verilog/dag_unit.sv
// data address generation unit: effective, paged and modulo addresses
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module dag_unit (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic op_valid,
   input wire logic [2:0] op_mode,
   input wire logic op_write,
   input wire logic [3:0] op_ptr_idx,
   input wire logic [3:0] op_base_idx,
   input wire logic op_file_default,
   input wire logic [12:0] op_file_addr,
   input wire logic [1:0] op_op2_sel,
   input wire logic [9:0] op_literal,
   input wire logic [15:0] op_step,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   output logic mem_valid,
   output logic mem_write,
   output logic [23:0] mem_addr,
   output logic mem_psv,
   output logic [15:0] op1_value,
   output logic [15:0] op2_value,
   output logic [3:0] dest_reg_idx
);
   // register offsets (byte addresses)
   localparam logic [7:0] OFS_READ_PAGE = 8'h00;
   localparam logic [7:0] OFS_WRITE_PAGE = 8'h04;
   localparam logic [7:0] OFS_MOD_CTRL = 8'h08;
   localparam logic [7:0] OFS_MOD_START = 8'h0c;
   localparam logic [7:0] OFS_MOD_END = 8'h10;
   localparam logic [7:0] OFS_LAST_EA = 8'h14;
   localparam logic [7:0] OFS_DEFAULT_WORK_REG_BASE = 8'h40;

   logic [9:0] read_page_reg;
   logic [8:0] write_page_reg;
   logic [3:0] mod_sel_reg;
   logic mod_en_reg;
   logic [15:0] mod_start_reg;
   logic [15:0] mod_end_reg;
   logic [15:0] last_ea_reg;
   localparam int unsigned NREG_L = dag_pkg::NREG;
   logic [15:0] work_reg [NREG_L];
   logic ack_reg;

   // zero extension of a literal by operand form
   function automatic logic [15:0] lit_ext(input logic [1:0] sel, input logic [9:0] lit);
      if (sel == 2'(dag_pkg::DAG_OP2_LIT5)) begin
         lit_ext = {11'h000, lit[4:0]};
      end else begin
         lit_ext = {6'h00, lit};
      end
   endfunction

   // wrap an address that overshoots a boundary in the step direction
   function automatic logic [15:0] modulo_fix(input logic [15:0] a, input logic down,
                                              input logic [15:0] lo, input logic [15:0] hi);
      logic [15:0] span;
      span = 16'(hi - lo + 16'h0001);
      if (!down && (a > hi)) begin
         modulo_fix = 16'(a - span);
      end else if (down && (a < lo)) begin
         modulo_fix = 16'(a + span);
      end else begin
         modulo_fix = a;
      end
   endfunction

   // ---------------- bus slave ----------------
   logic bus_req;
   logic bus_wr;
   logic bus_hit;
   logic [31:0] rd_data;
   // an error answer also blocks a second take of the same held request
   assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg && !wb_err_o;
   assign bus_wr = bus_req && wb_we_i && wb_sel_i[0] && wb_sel_i[1];

   always_comb begin
      bus_hit = 1'b1;
      rd_data = 32'h0000_0000;
      if (wb_adr_i == OFS_READ_PAGE) begin
         rd_data = {22'h000000, read_page_reg};
      end else if (wb_adr_i == OFS_WRITE_PAGE) begin
         rd_data = {23'h000000, write_page_reg};
      end else if (wb_adr_i == OFS_MOD_CTRL) begin
         rd_data = {27'h0000000, mod_en_reg, mod_sel_reg};
      end else if (wb_adr_i == OFS_MOD_START) begin
         rd_data = {16'h0000, mod_start_reg};
      end else if (wb_adr_i == OFS_MOD_END) begin
         rd_data = {16'h0000, mod_end_reg};
      end else if (wb_adr_i == OFS_LAST_EA) begin
         rd_data = {16'h0000, last_ea_reg};
      end else if (wb_adr_i[7:6] == OFS_DEFAULT_WORK_REG_BASE[7:6] && wb_adr_i[1:0] == 2'h0) begin
         rd_data = {16'h0000, work_reg[wb_adr_i[5:2]]};
      end else begin
         bus_hit = 1'b0;
      end
   end

   // single-wait answer; ack drops the cycle after it is given
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         ack_reg <= bus_req && bus_hit;
         wb_err_o <= bus_req && !bus_hit;
         wb_dat_o <= (bus_req && bus_hit && !wb_we_i) ? rd_data : 32'h0000_0000;
      end
   end
   assign wb_ack_o = ack_reg;

   // writes take effect on the acknowledge edge, as the master expects
   logic wr_now;
   assign wr_now = ack_reg && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_sel_i[1];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         read_page_reg <= dag_pkg::READ_PAGE_RST;
         write_page_reg <= dag_pkg::WRITE_PAGE_RST;
      end else if (wr_now && wb_adr_i == OFS_READ_PAGE) begin
         read_page_reg <= wb_dat_i[9:0];
      end else if (wr_now && wb_adr_i == OFS_WRITE_PAGE) begin
         write_page_reg <= wb_dat_i[8:0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mod_sel_reg <= dag_pkg::MOD_SEL_NONE;
         mod_en_reg <= 1'b0;
         mod_start_reg <= dag_pkg::MOD_START_RST;
         mod_end_reg <= dag_pkg::MOD_END_RST;
      end else if (wr_now && wb_adr_i == OFS_MOD_CTRL) begin
         mod_sel_reg <= wb_dat_i[3:0];
         mod_en_reg <= wb_dat_i[4];
      end else if (wr_now && wb_adr_i == OFS_MOD_START) begin
         mod_start_reg <= wb_dat_i[15:0];
      end else if (wr_now && wb_adr_i == OFS_MOD_END) begin
         mod_end_reg <= wb_dat_i[15:0];
      end
   end
   logic unused_bus;
   assign unused_bus = bus_wr;

   // ---------------- address generation ----------------
   dag_pkg::dag_mode_e mode;
   logic [15:0] ptr_val;
   logic [15:0] base_val;
   logic [15:0] lit_val;
   logic [15:0] stepped;
   logic [15:0] raw_ea;
   logic [15:0] ea;
   logic [15:0] ptr_next;
   logic ptr_wb;
   logic mod_hit;
   logic step_down;
   logic mem_access;
   logic [3:0] dest_idx;

   assign mode = dag_pkg::dag_mode_e'(op_mode);
   assign ptr_val = work_reg[op_ptr_idx];
   assign base_val = work_reg[op_base_idx];
   assign lit_val = lit_ext(op_op2_sel, op_literal);
   assign stepped = 16'(ptr_val + op_step);
   assign step_down = op_step[15];
   // any pointer register may be the modulo pointer
   assign mod_hit = mod_en_reg && (mod_sel_reg == op_ptr_idx);

   always_comb begin
      raw_ea = 16'h0000;
      mem_access = 1'b1;
      ptr_wb = 1'b0;
      case (mode)
         dag_pkg::DAG_FILE_DIRECT: begin
            raw_ea = {3'h0, op_file_addr};
         end
         dag_pkg::DAG_INDIRECT: begin
            raw_ea = ptr_val;
         end
         dag_pkg::DAG_POST_MOD: begin
            raw_ea = ptr_val;
            ptr_wb = 1'b1;
         end
         dag_pkg::DAG_PRE_MOD: begin
            raw_ea = stepped;
            ptr_wb = 1'b1;
         end
         dag_pkg::DAG_REG_INDEXED: begin
            raw_ea = 16'(ptr_val + base_val);
         end
         dag_pkg::DAG_LIT_OFFSET: begin
            raw_ea = 16'(ptr_val + lit_val);
         end
         default: begin
            mem_access = 1'b0; // register direct and literal touch no memory
         end
      endcase
   end

   // offset forms are corrected but never written back
   always_comb begin
      ea = raw_ea;
      if (mod_hit && mode != dag_pkg::DAG_FILE_DIRECT && mode != dag_pkg::DAG_POST_MOD) begin
         ea = modulo_fix(raw_ea, step_down, mod_start_reg, mod_end_reg);
      end
   end

   // pre- and post-modify: the stepped pointer, wrapped, goes back
   assign ptr_next = mod_hit ? modulo_fix(stepped, step_down, mod_start_reg, mod_end_reg)
                             : stepped;

   // ops with op_file_default set go to register zero in any mode, others to base register
   assign dest_idx = op_file_default ? dag_pkg::DEFAULT_WORK_REG_ZERO_IDX : op_base_idx;

   // pointer write-back beats a bus write to any work register in the same cycle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NREG_L; i++) begin
            work_reg[i] <= dag_pkg::DEFAULT_WORK_REG_RST;
         end
      end else if (op_valid && ptr_wb) begin
         work_reg[op_ptr_idx] <= ptr_next;
      end else if (wr_now && wb_adr_i[7:6] == OFS_DEFAULT_WORK_REG_BASE[7:6]) begin
         work_reg[wb_adr_i[5:2]] <= wb_dat_i[15:0];
      end
   end

   // paged address forming, registered to the memory port
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_valid <= 1'b0;
         mem_write <= 1'b0;
         mem_addr <= 24'h000000;
         mem_psv <= 1'b0;
         last_ea_reg <= 16'h0000;
      end else begin
         mem_valid <= op_valid && mem_access;
         mem_write <= op_valid && mem_access && op_write;
         mem_psv <= 1'b0;
         if (op_valid && mem_access) begin
            last_ea_reg <= ea;
            if (!ea[dag_pkg::EA_TOP_BIT]) begin
               mem_addr <= {8'h00, ea};
            end else if (op_write) begin
               mem_addr <= {write_page_reg[8:0], ea[14:0]};
            end else if (!read_page_reg[dag_pkg::RPAG_PSV_BIT]) begin
               mem_addr <= {read_page_reg[8:0], ea[14:0]};
            end else begin
               // program-space window reads leave the mapping to the fetch side
               mem_addr <= {read_page_reg[8:0], ea[14:0]};
               mem_psv <= 1'b1;
            end
         end
      end
   end

   // operand outputs: op1 always base register direct
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         op1_value <= 16'h0000;
         op2_value <= 16'h0000;
         dest_reg_idx <= 4'h0;
      end else if (op_valid) begin
         op1_value <= base_val;
         op2_value <= (op_op2_sel == 2'(dag_pkg::DAG_OP2_REG)) ? ptr_val : lit_val;
         dest_reg_idx <= dest_idx;
      end
   end
endmodule
`default_nettype wire

// file: dv/dag_unit_assertions.sv
// checker: port-level assertions for the address unit
`timescale 1ns/1ns
`default_nettype none
module dag_unit_chk (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic op_valid,
   input wire logic [2:0] op_mode,
   input wire logic op_write,
   input wire logic op_file_default,
   input wire logic [12:0] op_file_addr,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic mem_valid,
   input wire logic mem_write,
   input wire logic [23:0] mem_addr,
   input wire logic mem_psv,
   input wire logic [3:0] dest_reg_idx
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   a_ack_on_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
      |=> wb_ack_o || wb_err_o) else $error("no bus answer");
   a_no_stray: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
      else $error("stray answer");
   a_mem_from_op: assert property (mem_valid |-> $past(op_valid)) else $error("mem no op");
   a_file_addr: assert property (op_valid && op_mode == 3'h0 |=> mem_valid &&
      mem_addr == {11'h0, $past(op_file_addr)}) else $error("file addr");
   a_dir_nomem: assert property (op_valid && op_mode == 3'h1 |=> !mem_valid)
      else $error("direct hit memory");
   a_write_dir: assert property (mem_valid |-> mem_write == $past(op_write))
      else $error("direction");
   a_psv_read: assert property (mem_psv |-> !mem_write) else $error("psv write");
   a_dest_zero: assert property (op_valid && op_mode == 3'h0 && op_file_default
      |=> dest_reg_idx == 4'h0) else $error("dest not zero");
endmodule
bind dag_unit dag_unit_chk dag_unit_chk_i (.core_clk, .rst_n, .op_valid, .op_mode,
   .op_write, .op_file_default, .op_file_addr, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
   .wb_err_o, .mem_valid, .mem_write, .mem_addr, .mem_psv, .dest_reg_idx);
`default_nettype wire

// file: dv/dag_mem_model.sv
// data memory port model: counts accesses it is handed
`timescale 1ns/1ns
`default_nettype none
module dag_mem_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic mem_valid,
   output int n_acc
);
   // one access per valid cycle, so back to back ops are counted apart
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         n_acc <= 0;
      end else if (mem_valid) begin
         n_acc <= n_acc + 1;
      end
   end
endmodule
`default_nettype wire

// file: dv/data_address_generation_tb_top.sv
// testbench: random and corner address ops with bus setup
`timescale 1ns/1ns
`default_nettype none
module data_address_generation_tb_top;
   logic core_clk = 0, rst_n = 1, op_valid = 0, op_write = 0, op_file_default = 0;
   logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, w, e, wb_ack_o, wb_err_o;
   logic mem_valid, mem_write, mem_psv;
   logic [2:0] op_mode = 0, m;
   logic [3:0] op_ptr_idx = 0, op_base_idx = 0, wb_sel_i = 4'hf, dest_reg_idx;
   logic [12:0] op_file_addr = 0;
   logic [1:0] op_op2_sel = 0;
   logic [9:0] op_literal = 0, lit;
   logic [15:0] op_step = 0, p, q, st, op1_value, op2_value;
   logic [7:0] wb_adr_i = 0;
   logic [8:0] rp, wp;
   logic [31:0] wb_dat_i = 0, wb_dat_o, rd, seed = 32'hbd38b118;
   logic [23:0] mem_addr;
   int n_mismatch = 0, n_compared = 0, n_mem = 0, n_acc;
   dag_unit dag_unit_i (.core_clk, .rst_n, .op_valid, .op_mode, .op_write, .op_ptr_idx,
      .op_base_idx, .op_file_default, .op_file_addr, .op_op2_sel, .op_literal, .op_step,
      .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .wb_err_o, .mem_valid, .mem_write, .mem_addr, .mem_psv, .op1_value, .op2_value,
      .dest_reg_idx);
   dag_mem_model dag_mem_model_i (.core_clk, .rst_n, .mem_valid, .n_acc);
   initial begin
      forever #2 core_clk = ~core_clk;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // paged address: top bit clear passes unpaged
   function automatic logic [23:0] xa(logic [15:0] a, logic wr);
      return a[15] ? {(wr ? wp : rp), a[14:0]} : {8'h0, a};
   endfunction
   function automatic logic [15:0] ea_of(logic [2:0] md);
      case (md)
         3'h0: return {3'h0, p[12:0]};
         3'h4: return p + st;
         3'h5: return p + q;
         3'h6: return p + (q[2] ? {11'h0, lit[4:0]} : {6'h0, lit});
         default: return p;
      endcase
   endfunction
   task chk(input logic [31:0] g, input logic [31:0] x);
      n_compared++;
      if (g !== x) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= wr;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge core_clk);
      while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) @(posedge core_clk);
      rd = wb_dat_o;
      e = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task op(input logic [2:0] md, input logic wr, input logic [3:0] pi, input logic [3:0] bi);
      @(posedge core_clk);
      op_valid <= 1'b1;
      op_mode <= md;
      op_write <= wr;
      op_ptr_idx <= pi;
      op_base_idx <= bi;
      op_step <= st;
      op_literal <= lit;
      op_file_addr <= p[12:0];
      op_file_default <= p[13];
      op_op2_sel <= {1'b0, q[2]};
      @(posedge core_clk);
      op_valid <= 1'b0;
      #1;
      if (md != 3'h1 && md != 3'h7) n_mem++;
   endtask
   // modulo case: pointer r, base in register 14, expected address and pointer
   task mo(input logic [3:0] r, input logic [2:0] md, input logic [15:0] a, b, s, x, pe);
      bus(1'b1, {2'h1, r, 2'h0}, {16'h0, a});
      bus(1'b1, 8'h78, {16'h0, b});
      st = s;
      p = a;
      op(md, 1'b0, r, 4'he);
      chk({8'h0, mem_addr}, {16'h0, x});
      bus(1'b0, {2'h1, r, 2'h0}, 32'h0);
      chk(rd, {16'h0, pe});
   endtask
   task tally_and_finish();
      $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #60000;
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      rst_n <= 1'b0;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      bus(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h1);
      bus(1'b0, 8'h10, 32'h0);
      chk(rd, 32'hffff);
      bus(1'b1, 8'h00, 32'hffff);
      bus(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h3ff);
      bus(1'b1, 8'h04, 32'hffff);
      bus(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h1ff);
      bus(1'b0, 8'h80, 32'h0);
      chk({31'h0, e}, 32'h1);
      p = 16'h8abc;
      bus(1'b1, 8'h4c, {16'h0, p});
      op(3'h2, 1'b0, 4'h3, 4'h4);
      chk({31'h0, mem_psv}, 32'h1);
      rp = xs();
      wp = xs();
      bus(1'b1, 8'h00, {23'h0, rp});
      bus(1'b1, 8'h04, {23'h0, wp});
      // every mode in turn with random pointers, steps and directions
      for (int i = 0; i < 48; i++) begin
         p = xs();
         q = xs();
         st = xs();
         lit = {1'b0, q[12:4]};
         m = 3'(i);
         w = st[7];
         bus(1'b1, 8'h4c, {16'h0, p});
         bus(1'b1, 8'h50, {16'h0, q});
         op(m, w, 4'h3, 4'h4);
         if (m != 3'h1 && m != 3'h7) chk({8'h0, mem_addr}, {8'h0, xa(ea_of(m), w)});
         chk({16'h0, op2_value}, {16'h0, q[2] ? {11'h0, lit[4:0]} : p});
         chk({16'h0, op1_value}, {16'h0, q});
         chk({28'h0, dest_reg_idx}, p[13] ? 32'h0 : 32'h4);
         bus(1'b0, 8'h4c, 32'h0);
         chk(rd, {16'h0, (m == 3'h3 || m == 3'h4) ? p + st : p});
      end
      bus(1'b1, 8'h0c, 32'h1000);
      bus(1'b1, 8'h10, 32'h101f);
      for (int r = 3; r < 12; r += 6) begin
         bus(1'b1, 8'h08, {27'h1, 4'(r)});
         mo(4'(r), 3'h3, 16'h101e, 16'h0, 16'h0004, 16'h101e, 16'h1002);
         mo(4'(r), 3'h4, 16'h1000, 16'h0, 16'hfffe, 16'h101e, 16'h101e);
         mo(4'(r), 3'h5, 16'h1010, 16'h0015, 16'h0, 16'h1005, 16'h1010);
      end
      chk(n_acc, n_mem);
      tally_and_finish();
   end
endmodule
`default_nettype wire
